// File: rtl/charger_control_regs.sv
// Charger control registers four and five with their locks and self-clearing detect
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] The second input-path gate drive follows its bit, held at 0 when that path is absent.
// [R2] The first input-path gate drive follows its bit, held at 0 when that path is absent.
// [R3] Frequency select is 0 for 1.5 MHz and 1 for 750 kHz, starting from the strap pin.
// [R4] The indicator-off bit disables the status pin; it clears on watchdog or register reset.
// [R5] The rail-short hiccup-off bit disables that protection; only register reset clears it.
// [R6] The forced detect bit can be set only while battery is above minimum system voltage.
// [R7] A forced detect halts switching, measures the bus and rewrites the input voltage limit.
// [R8] The forced detect bit clears itself when detection completes, and on register reset.
// [R9] The bus overcurrent enable gates that protection; it resets to 1 on register reset.
// [R10] Without a fitted ship switch the battery overcurrent and ship switch fields stay 0.
// [R11] Once the ship switch is marked fitted the gated ship switch fields become writable.
// [R12] The battery current monitor output enable clears on watchdog or register reset.
// [R13] The internal input current limit enable returns to 1 on watchdog or register reset.
// [R14] The external limit pin enable returns to 1 only on register reset.
// [R15] The battery discharge protection enable clears on watchdog or register reset.
// [R16] The separate driver-off control forces both gate drive bits to 0.
// [R17] Each event resets only its own marked fields; all others keep their values.
module charger_control_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire charger_ctrl_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic watchdog_expired,
    input wire logic register_reset,
    input wire logic input_gate_drivers_off,
    input wire logic config_strap_pin,
    input wire logic first_input_path_switch_seen,
    input wire logic second_input_path_switch_seen,
    input wire logic vbat_above_minimum_system_voltage,
    input wire logic adc_done,
    input wire logic [7:0] adc_vbus,
    output logic input_path_two_gate_en,
    output logic input_path_one_gate_en,
    output logic switching_freq_sel,
    output logic indicator_pin_off,
    output logic rail_short_hiccup_off,
    output logic force_input_volt_limit_detect,
    output logic bus_overcurrent_protect_en,
    output logic ship_switch_fitted,
    output logic battery_current_monitor_out_en,
    output logic internal_input_current_limit_en,
    output logic external_current_limit_pin_en,
    output logic battery_discharge_protect_en,
    output logic converter_halt,
    output logic adc_measure_req,
    output logic input_voltage_limit_wr,
    output logic [7:0] input_voltage_limit
);

    //////////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic path_two_en;
        logic path_one_en;
        logic freq_sel;
        logic indicator_off;
        logic short_off;
        logic force_det;
        logic bus_ocp_en;
        logic ship_fitted;
        logic ibat_out_en;
        logic iin_limit_en;
        logic ext_limit_en;
        logic batoc_en;
        logic strap_taken;
        logic path_one_fitted;
        logic path_two_fitted;
        logic [1:0] por_wait;
        logic det_start;
        logic [7:0] rdata;
        logic rd_valid;
    } ctrl_state_t;

    ctrl_state_t st_ff;
    ctrl_state_t nxt_st;

    logic [3:0] pins_sync;
    logic strap_sync;
    logic path_one_sync;
    logic path_two_sync;
    logic vbat_ok_sync;
    logic det_done;
    logic wr_four;
    logic wr_five;
    logic [7:0] wd;

    //////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    sync_bits #(
        .WIDTH(4)
    ) u_pin_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({vbat_above_minimum_system_voltage, second_input_path_switch_seen,
                   first_input_path_switch_seen, config_strap_pin}),
        .sync_out(pins_sync)
    );

    assign strap_sync = pins_sync[0];
    assign path_one_sync = pins_sync[1];
    assign path_two_sync = pins_sync[2];
    assign vbat_ok_sync = pins_sync[3];

    //////////////////////////////////////////////////////////////////////////////////////
    // Forced input-voltage-limit detection sequencer

    input_limit_detect u_detect (
        .core_clk(core_clk),
        .reset(reset),
        .start(st_ff.det_start),
        .adc_done(adc_done),
        .adc_vbus(adc_vbus),
        .converter_halt(converter_halt),
        .adc_measure_req(adc_measure_req),
        .limit_wr(input_voltage_limit_wr),
        .limit_val(input_voltage_limit),
        .done(det_done)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Next state

    assign wr_four = reg_req.wr && (reg_req.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR);
    assign wr_five = reg_req.wr && (reg_req.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR);
    assign wd = reg_req.wdata;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.det_start = 1'b0;
        nxt_st.rd_valid = 1'b0;

        // Power-on capture of strap and path presence once the synchroniser has settled
        if (st_ff.por_wait != charger_ctrl_pkg::STRAP_WAIT) begin
            nxt_st.por_wait = st_ff.por_wait + 2'h1;
        end else if (!st_ff.strap_taken) begin
            nxt_st.strap_taken = 1'b1;
            nxt_st.freq_sel = strap_sync; // R3
            nxt_st.path_one_fitted = path_one_sync;
            nxt_st.path_two_fitted = path_two_sync;
        end

        // Completion clears first so that a new set in the same cycle survives
        if (det_done) begin
            nxt_st.force_det = 1'b0; // R8
        end

        if (wr_four) begin
            // Locked at 0 until presence is known and while the path is absent
            nxt_st.path_two_en = wd[charger_ctrl_pkg::C4_PATH_TWO_BIT]
                && st_ff.strap_taken && st_ff.path_two_fitted; // R1
            nxt_st.path_one_en = wd[charger_ctrl_pkg::C4_PATH_ONE_BIT]
                && st_ff.strap_taken && st_ff.path_one_fitted; // R2
            nxt_st.freq_sel = wd[charger_ctrl_pkg::C4_FREQ_BIT]; // R3
            nxt_st.indicator_off = wd[charger_ctrl_pkg::C4_INDICATOR_BIT]; // R4
            nxt_st.short_off = wd[charger_ctrl_pkg::C4_SHORT_BIT]; // R5
            nxt_st.bus_ocp_en = wd[charger_ctrl_pkg::C4_BUS_OCP_BIT]; // R9
            // Writing 0 never aborts a run; the bit clears only on completion or register reset
            if (wd[charger_ctrl_pkg::C4_FORCE_DET_BIT] && vbat_ok_sync
                    && !nxt_st.force_det) begin
                nxt_st.force_det = 1'b1; // R6
                nxt_st.det_start = 1'b1; // R7
            end
        end

        if (wr_five) begin
            nxt_st.ship_fitted = wd[charger_ctrl_pkg::C5_SHIP_FITTED_BIT]; // R11
            nxt_st.ibat_out_en = wd[charger_ctrl_pkg::C5_IBAT_OUT_BIT]; // R12
            nxt_st.iin_limit_en = wd[charger_ctrl_pkg::C5_IIN_LIMIT_BIT]; // R13
            nxt_st.ext_limit_en = wd[charger_ctrl_pkg::C5_EXT_LIMIT_BIT]; // R14
            nxt_st.batoc_en = wd[charger_ctrl_pkg::C5_BATOC_BIT]; // R15
        end

        // Watchdog expiry restores only the fields it owns
        if (watchdog_expired) begin
            nxt_st.indicator_off = 1'b0; // R4
            nxt_st.ibat_out_en = 1'b0; // R12
            nxt_st.iin_limit_en = 1'b1; // R13
            nxt_st.batoc_en = 1'b0; // R15
        end

        // Register reset; gate drives, frequency and ship presence are kept
        if (register_reset) begin
            nxt_st.indicator_off = 1'b0; // R4
            nxt_st.short_off = 1'b0; // R5
            nxt_st.force_det = 1'b0; // R8
            nxt_st.bus_ocp_en = 1'b1; // R9
            nxt_st.ibat_out_en = 1'b0; // R12
            nxt_st.iin_limit_en = 1'b1; // R13
            nxt_st.ext_limit_en = 1'b1; // R14
            nxt_st.batoc_en = 1'b0; // R15
            nxt_st.det_start = 1'b0;
        end

        // Ship switch gating applies after every write source
        if (!nxt_st.ship_fitted) begin
            nxt_st.batoc_en = 1'b0; // R10
        end

        // Separate driver-off control overrides anything written
        if (input_gate_drivers_off) begin
            nxt_st.path_two_en = 1'b0; // R16
            nxt_st.path_one_en = 1'b0; // R16
        end

        // Read data reflects the register contents before this cycle's write
        if (reg_req.rd) begin
            nxt_st.rd_valid = 1'b1;
            nxt_st.rdata = charger_ctrl_pkg::UNMAPPED_VALUE;
            if (reg_req.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR) begin
                nxt_st.rdata[charger_ctrl_pkg::C4_PATH_TWO_BIT] = st_ff.path_two_en;
                nxt_st.rdata[charger_ctrl_pkg::C4_PATH_ONE_BIT] = st_ff.path_one_en;
                nxt_st.rdata[charger_ctrl_pkg::C4_FREQ_BIT] = st_ff.freq_sel;
                nxt_st.rdata[charger_ctrl_pkg::C4_INDICATOR_BIT] = st_ff.indicator_off;
                nxt_st.rdata[charger_ctrl_pkg::C4_SHORT_BIT] = st_ff.short_off;
                nxt_st.rdata[charger_ctrl_pkg::C4_FORCE_DET_BIT] = st_ff.force_det;
                nxt_st.rdata[charger_ctrl_pkg::C4_BUS_OCP_BIT] = st_ff.bus_ocp_en;
            end else if (reg_req.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR) begin
                nxt_st.rdata = charger_ctrl_pkg::C5_RSVD_VALUE;
                nxt_st.rdata[charger_ctrl_pkg::C5_SHIP_FITTED_BIT] = st_ff.ship_fitted;
                nxt_st.rdata[charger_ctrl_pkg::C5_IBAT_OUT_BIT] = st_ff.ibat_out_en;
                nxt_st.rdata[charger_ctrl_pkg::C5_IIN_LIMIT_BIT] = st_ff.iin_limit_en;
                nxt_st.rdata[charger_ctrl_pkg::C5_EXT_LIMIT_BIT] = st_ff.ext_limit_en;
                nxt_st.rdata[charger_ctrl_pkg::C5_BATOC_BIT] = st_ff.batoc_en;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.bus_ocp_en <= charger_ctrl_pkg::C4_RESET_FIXED[charger_ctrl_pkg::C4_BUS_OCP_BIT];
            st_ff.iin_limit_en <= charger_ctrl_pkg::C5_RESET[charger_ctrl_pkg::C5_IIN_LIMIT_BIT];
            st_ff.ext_limit_en <= charger_ctrl_pkg::C5_RESET[charger_ctrl_pkg::C5_EXT_LIMIT_BIT];
        end else begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = st_ff.rdata;
    assign reg_rd_valid = st_ff.rd_valid;
    assign input_path_two_gate_en = st_ff.path_two_en; // R1
    assign input_path_one_gate_en = st_ff.path_one_en; // R2
    assign switching_freq_sel = st_ff.freq_sel; // R3
    assign indicator_pin_off = st_ff.indicator_off; // R4
    assign rail_short_hiccup_off = st_ff.short_off; // R5
    assign force_input_volt_limit_detect = st_ff.force_det;
    assign bus_overcurrent_protect_en = st_ff.bus_ocp_en; // R9
    // Other blocks hold the ship switch fields at 0 while this is low
    assign ship_switch_fitted = st_ff.ship_fitted; // R11
    assign battery_current_monitor_out_en = st_ff.ibat_out_en; // R12
    assign internal_input_current_limit_en = st_ff.iin_limit_en; // R13
    assign external_current_limit_pin_en = st_ff.ext_limit_en; // R14
    assign battery_discharge_protect_en = st_ff.batoc_en; // R15

endmodule : charger_control_regs
`default_nettype wire

// File: pkg/charger_ctrl_pkg.sv
// Shared constants and types for the charger control register bank
package charger_ctrl_pkg;

    localparam logic [7:0] CTRL_FOUR_ADDR = 8'h13;
    localparam logic [7:0] CTRL_FIVE_ADDR = 8'h14;

    localparam int C4_PATH_TWO_BIT = 7;
    localparam int C4_PATH_ONE_BIT = 6;
    localparam int C4_FREQ_BIT = 5;
    localparam int C4_INDICATOR_BIT = 4;
    localparam int C4_SHORT_BIT = 3;
    localparam int C4_FORCE_DET_BIT = 1;
    localparam int C4_BUS_OCP_BIT = 0;

    localparam int C5_SHIP_FITTED_BIT = 7;
    localparam int C5_IBAT_OUT_BIT = 5;
    localparam int C5_IIN_LIMIT_BIT = 2;
    localparam int C5_EXT_LIMIT_BIT = 1;
    localparam int C5_BATOC_BIT = 0;

    // Value that the reserved bits 6 and 4-3 of the second register always read
    localparam logic [7:0] C5_RSVD_VALUE = 8'h10;
    localparam logic [7:0] C4_RESET_FIXED = 8'h01;
    localparam logic [7:0] C5_RESET = 8'h16;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // Edges after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    localparam int CLK_PERIOD_NS = 5;
    localparam int HALT_SETTLE_NS = 1000;
    localparam int HALT_SETTLE_CYCLES = (HALT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b00,
        DET_HALT = 2'b01,
        DET_MEASURE = 2'b10,
        DET_UPDATE = 2'b11
    } det_phase_t;

    typedef struct packed {
        det_phase_t phase;
        logic [7:0] cnt;
        logic halt;
        logic adc_req;
        logic limit_wr;
        logic [7:0] limit_val;
        logic done;
    } det_state_t;

endpackage : charger_ctrl_pkg

// File: rtl/sync_bits.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st.stage_one = async_in;
        nxt_st.stage_two = st_ff.stage_one;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stage_two;
endmodule : sync_bits
`default_nettype wire

// File: rtl/input_limit_detect.sv
// Sequencer for the forced input-voltage-limit detection
`timescale 1ns/1ps
`default_nettype none
module input_limit_detect (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic adc_done,
    input wire logic [7:0] adc_vbus,
    output logic converter_halt,
    output logic adc_measure_req,
    output logic limit_wr,
    output logic [7:0] limit_val,
    output logic done
);
    localparam logic [7:0] SETTLE_LAST = 8'(charger_ctrl_pkg::HALT_SETTLE_CYCLES - 1);

    charger_ctrl_pkg::det_state_t st_ff;
    charger_ctrl_pkg::det_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.adc_req = 1'b0;
        nxt_st.limit_wr = 1'b0;
        nxt_st.done = 1'b0;
        case (st_ff.phase)
            charger_ctrl_pkg::DET_IDLE: begin
                if (start) begin
                    // Stop switching first so the bus carries no input current
                    nxt_st.phase = charger_ctrl_pkg::DET_HALT; // R7
                    nxt_st.halt = 1'b1;
                    nxt_st.cnt = 8'h00;
                end
            end
            charger_ctrl_pkg::DET_HALT: begin
                nxt_st.cnt = st_ff.cnt + 8'h01;
                if (st_ff.cnt == SETTLE_LAST) begin
                    nxt_st.phase = charger_ctrl_pkg::DET_MEASURE;
                    nxt_st.adc_req = 1'b1; // R7
                end
            end
            charger_ctrl_pkg::DET_MEASURE: begin
                if (adc_done) begin
                    nxt_st.limit_val = adc_vbus; // R7
                    nxt_st.limit_wr = 1'b1;
                    // Done leads by a cycle so the bit clears on the edge that drops halt
                    nxt_st.done = 1'b1; // R8
                    nxt_st.phase = charger_ctrl_pkg::DET_UPDATE;
                end
            end
            charger_ctrl_pkg::DET_UPDATE: begin
                nxt_st.halt = 1'b0;
                nxt_st.phase = charger_ctrl_pkg::DET_IDLE;
            end
            default: begin
                nxt_st = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign converter_halt = st_ff.halt;
    assign adc_measure_req = st_ff.adc_req;
    assign limit_wr = st_ff.limit_wr;
    assign limit_val = st_ff.limit_val;
    assign done = st_ff.done;
endmodule : input_limit_detect
`default_nettype wire

// File: verif/adc_model.sv
// Behavioural ADC answering the detect sequencer's measurement request
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
    parameter int LATENCY = 20,
    parameter logic [7:0] VBUS = 8'h5a
) (
    input wire logic core_clk,
    input wire logic adc_measure_req,
    output logic adc_done,
    output logic [7:0] adc_vbus
);
    int cnt = 0;
    initial begin
        adc_done = 1'b0;
        adc_vbus = ~VBUS;
    end
    always @(posedge core_clk) begin
        adc_done <= 1'b0;
        // Result lines toggle outside the done cycle so stale data never looks valid
        adc_vbus <= ~adc_vbus;
        if (adc_measure_req) begin
            cnt <= LATENCY;
        end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_vbus <= VBUS;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : adc_model
`default_nettype wire

// File: verif/charger_control_regs_chk.sv
// Assertion checker for the charger control register bank
`timescale 1ns/1ps
`default_nettype none
module charger_control_regs_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire charger_ctrl_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic watchdog_expired,
    input wire logic register_reset,
    input wire logic input_gate_drivers_off,
    input wire logic adc_done,
    input wire logic [7:0] adc_vbus,
    input wire logic input_path_two_gate_en,
    input wire logic input_path_one_gate_en,
    input wire logic switching_freq_sel,
    input wire logic indicator_pin_off,
    input wire logic rail_short_hiccup_off,
    input wire logic force_input_volt_limit_detect,
    input wire logic bus_overcurrent_protect_en,
    input wire logic ship_switch_fitted,
    input wire logic battery_current_monitor_out_en,
    input wire logic internal_input_current_limit_en,
    input wire logic external_current_limit_pin_en,
    input wire logic battery_discharge_protect_en,
    input wire logic converter_halt,
    input wire logic adc_measure_req,
    input wire logic input_voltage_limit_wr,
    input wire logic [7:0] input_voltage_limit
);
    logic [7:0] four_v;
    logic [7:0] five_v;
    logic rd_four;
    logic rd_five;
    assign four_v = {input_path_two_gate_en, input_path_one_gate_en, switching_freq_sel,
        indicator_pin_off, rail_short_hiccup_off, 1'b0, force_input_volt_limit_detect,
        bus_overcurrent_protect_en};
    assign five_v = {ship_switch_fitted, 1'b0, battery_current_monitor_out_en, 2'b10,
        internal_input_current_limit_en, external_current_limit_pin_en,
        battery_discharge_protect_en};
    assign rd_four = reg_req.rd && reg_req.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR;
    assign rd_five = reg_req.rd && reg_req.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    property p_drv_off;
        input_gate_drivers_off |=> !input_path_one_gate_en && !input_path_two_gate_en;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("gate enable survived driver-off");
    property p_wdog_clr;
        watchdog_expired |=> !indicator_pin_off && !battery_current_monitor_out_en
            && internal_input_current_limit_en && !battery_discharge_protect_en;
    endproperty
    a_wdog_clr: assert property (p_wdog_clr) else $error("watchdog defaults not applied");
    property p_wdog_keep;
        watchdog_expired && !register_reset && !reg_req.wr |=> $stable(rail_short_hiccup_off)
            && $stable(external_current_limit_pin_en) && $stable(bus_overcurrent_protect_en);
    endproperty
    a_wdog_keep: assert property (p_wdog_keep) else $error("watchdog hit a kept field");
    property p_rreg;
        register_reset |=> !rail_short_hiccup_off && bus_overcurrent_protect_en
            && external_current_limit_pin_en && !force_input_volt_limit_detect;
    endproperty
    a_rreg: assert property (p_rreg) else $error("register reset defaults wrong");
    property p_ship_lock;
        !ship_switch_fitted |-> !battery_discharge_protect_en;
    endproperty
    a_ship_lock: assert property (p_ship_lock) else $error("battery protect set unfitted");
    property p_det_halt;
        $rose(force_input_volt_limit_detect) |=> converter_halt;
    endproperty
    a_det_halt: assert property (p_det_halt) else $error("detect did not halt");
    property p_halt_req;
        $rose(converter_halt) |-> ##[199:201] adc_measure_req;
    endproperty
    a_halt_req: assert property (p_halt_req) else $error("measure request mistimed");
    property p_upd;
        adc_done && converter_halt |=> input_voltage_limit_wr
            && input_voltage_limit == $past(adc_vbus);
    endproperty
    a_upd: assert property (p_upd) else $error("limit not updated from adc");
    property p_self_clr;
        input_voltage_limit_wr |=> !converter_halt && !force_input_volt_limit_detect;
    endproperty
    a_self_clr: assert property (p_self_clr) else $error("detect bit did not clear");
    property p_rd_four;
        rd_four |=> reg_rd_valid && reg_rdata == $past(four_v);
    endproperty
    a_rd_four: assert property (p_rd_four) else $error("read of four wrong");
    property p_rd_five;
        rd_five |=> reg_rd_valid && reg_rdata == $past(five_v);
    endproperty
    a_rd_five: assert property (p_rd_five) else $error("read of five wrong");
    property p_rd_none;
        reg_req.rd && !rd_four && !rd_five |=> reg_rd_valid && reg_rdata == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
    c_det: cover property ($rose(converter_halt));
    c_wdog: cover property (watchdog_expired);
    c_lim: cover property (input_voltage_limit_wr);
endmodule : charger_control_regs_chk
bind charger_control_regs charger_control_regs_chk u_chk (.core_clk, .reset, .reg_req,
    .reg_rdata, .reg_rd_valid, .watchdog_expired, .register_reset, .input_gate_drivers_off,
    .adc_done, .adc_vbus, .input_path_two_gate_en, .input_path_one_gate_en,
    .switching_freq_sel, .indicator_pin_off, .rail_short_hiccup_off,
    .force_input_volt_limit_detect, .bus_overcurrent_protect_en, .ship_switch_fitted,
    .battery_current_monitor_out_en, .internal_input_current_limit_en,
    .external_current_limit_pin_en, .battery_discharge_protect_en, .converter_halt,
    .adc_measure_req, .input_voltage_limit_wr, .input_voltage_limit);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the charger control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    charger_ctrl_pkg::reg_req_t reg_req = '0;
    logic watchdog_expired = 1'b0, register_reset = 1'b0, input_gate_drivers_off = 1'b0;
    logic config_strap_pin = 1'b1, vbat_above_minimum_system_voltage = 1'b1;
    logic first_input_path_switch_seen = 1'b1, second_input_path_switch_seen = 1'b0;
    logic [7:0] reg_rdata, adc_vbus, input_voltage_limit;
    logic reg_rd_valid, adc_done, converter_halt, adc_measure_req, input_voltage_limit_wr;
    int error_cnt = 0;
    int samples_checked = 0;

    always #2.5 core_clk = ~core_clk;

    charger_control_regs dut (.core_clk, .reset, .reg_req, .reg_rdata, .reg_rd_valid,
        .watchdog_expired, .register_reset, .input_gate_drivers_off, .config_strap_pin,
        .first_input_path_switch_seen, .second_input_path_switch_seen,
        .vbat_above_minimum_system_voltage, .adc_done, .adc_vbus,
        .input_path_two_gate_en(), .input_path_one_gate_en(), .switching_freq_sel(),
        .indicator_pin_off(), .rail_short_hiccup_off(), .force_input_volt_limit_detect(),
        .bus_overcurrent_protect_en(), .ship_switch_fitted(),
        .battery_current_monitor_out_en(), .internal_input_current_limit_en(),
        .external_current_limit_pin_en(), .battery_discharge_protect_en(),
        .converter_halt, .adc_measure_req, .input_voltage_limit_wr, .input_voltage_limit);
    adc_model u_adc (.core_clk, .adc_measure_req, .adc_done, .adc_vbus);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        chk8({7'h00, reg_rd_valid}, 8'h01);
        chk8(reg_rdata, exp);
    endtask : rd
    // One-cycle pulse of {driver-off, watchdog, register reset}
    task automatic ev(input logic [2:0] m);
        @(posedge core_clk);
        {input_gate_drivers_off, watchdog_expired, register_reset} <= m;
        @(posedge core_clk);
        {input_gate_drivers_off, watchdog_expired, register_reset} <= 3'b000;
    endtask : ev
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(8'h13, 8'h21);
        rd(8'h14, 8'h16);
        wr(8'h15, 8'hff);
        rd(8'h15, 8'h00);
        $display("test reset_values done");
        wr(8'h13, 8'he1);
        rd(8'h13, 8'h61);
        ev(3'b100);
        rd(8'h13, 8'h21);
        wr(8'h13, 8'h01);
        rd(8'h13, 8'h01);
        $display("test gates_freq done");
        wr(8'h14, 8'h17);
        rd(8'h14, 8'h16);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'hb7);
        wr(8'h14, 8'h17);
        rd(8'h14, 8'h16);
        $display("test ship_lock done");
        wr(8'h13, 8'h38);
        wr(8'h14, 8'ha1);
        rd(8'h14, 8'hb1);
        ev(3'b010);
        rd(8'h13, 8'h28);
        rd(8'h14, 8'h94);
        ev(3'b001);
        rd(8'h13, 8'h21);
        rd(8'h14, 8'h96);
        $display("test resets done");
        @(posedge core_clk);
        vbat_above_minimum_system_voltage <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(8'h13, 8'h23);
        rd(8'h13, 8'h21);
        @(posedge core_clk);
        vbat_above_minimum_system_voltage <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(8'h13, 8'h23);
        rd(8'h13, 8'h23);
        chk8({7'h00, converter_halt}, 8'h01);
        for (int i = 0; i < 400 && input_voltage_limit_wr !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk8({7'h00, input_voltage_limit_wr}, 8'h01);
        chk8(input_voltage_limit, 8'h5a);
        rd(8'h13, 8'h21);
        $display("test force_detect done");
        end_of_test();
    end

    // Whole run is under a thousand cycles; this leaves ample margin
    initial begin
        #20000;
        error_cnt++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
